/* rtl/e1_loop_regs.svh */
// register offsets, field positions, reset values and timing constants of the loop/alarm block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef E1_LOOP_REGS_SVH
`define E1_LOOP_REGS_SVH

`define CC2_ADDR         8'h13
`define CC3_ADDR         8'h14
`define TX_MON_ADDR      8'h1e
`define LOOP_STAT_ADDR   8'h1f

`define CC2_RESET        8'h00
`define CC3_RESET        8'h00

// common_control_two fields
`define CC2_UPD_SEL      7
`define CC2_VIOL_SEL     6
`define CC2_AUTO_AIS     5
`define CC2_AUTO_RA      4
`define CC2_RX_SER_FORCE 3
`define CC2_CLK_LOSS_MUX 2
`define CC2_RCL_ALT      1
`define CC2_CLK_SRC_SEL  0
// common_control_three fields
`define CC3_REMOTE_LOOP  7
`define CC3_LOCAL_LOOP   6
`define CC3_LINE_AIS     5
`define CC3_MON_SEL_MSB  4
`define CC3_MON_SEL_LSB  0

`define REF_CLK_NS       5
`define UPD_SLOW_US      1000000
`define UPD_FAST_US      62500
`define CRC_LATE_US      128000
`define CRC_FAIL_US      400000
`define RCL_ZEROS_STD    12'h0ff
`define RCL_ZEROS_ALT    12'h800
`define TXCLK_DEAD_CYC   256

`endif

/* rtl/e1_loop_pkg.sv */
// types shared by the loop/alarm block
package e1_loop_pkg;
  typedef enum logic [1:0] {CRC_IDLE, CRC_SEARCH, CRC_FOUND} crc_state_e;
  typedef logic [7:0] reg_byte_t;
endpackage

/* rtl/e1_loopback_alarm_control.sv */
// loopback, clock source and automatic alarm control for one E1 channel
`timescale 1ns/1ps
`include "e1_loop_regs.svh"

//------------------------------------------------------------------------------
// dual clock transmit fifo
//------------------------------------------------------------------------------
module e1_tx_fifo #(
  parameter int W     = 2,
  parameter int DEPTH = 32
) (
  // write side
  input  wire logic         wclk_i,
  input  wire logic         wrst_i,
  input  wire logic         w_valid_i,
  input  wire logic [W-1:0] w_data_i,
  output logic              w_ready_o,
  // read side
  input  wire logic         rclk_i,
  input  wire logic         rrst_i,
  output logic              r_valid_o,
  input  wire logic         r_ready_i,
  output logic [W-1:0]      r_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 4");
  end

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_q, wgray_q, rbin_q, rgray_q;
  logic [AW:0]  rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;
  logic         do_wr, do_rd;

  // full compares against the read pointer seen two flops late: pessimistic, never overruns
  assign w_ready_o = wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]};
  assign r_valid_o = rgray_q != wg_s2_q;
  assign do_wr     = w_valid_i && w_ready_o;
  assign do_rd     = r_valid_o && r_ready_i;
  assign r_data_o  = mem[rbin_q[AW-1:0]];

  always_ff @(posedge wclk_i) begin
    if (do_wr) begin
      mem[wbin_q[AW-1:0]] <= w_data_i;
    end
  end

  always_ff @(posedge wclk_i) begin
    if (wrst_i) begin
      wbin_q  <= '0;
      wgray_q <= '0;
    end else if (do_wr) begin
      wbin_q  <= wbin_q + 1'b1;
      wgray_q <= to_gray(wbin_q + 1'b1);
    end
  end

  always_ff @(posedge wclk_i) begin
    if (wrst_i) begin
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
    end
  end

  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      rbin_q  <= '0;
      rgray_q <= '0;
    end else if (do_rd) begin
      rbin_q  <= rbin_q + 1'b1;
      rgray_q <= to_gray(rbin_q + 1'b1);
    end
  end

  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
    end
  end
endmodule // e1_tx_fifo

//------------------------------------------------------------------------------
// top level
//------------------------------------------------------------------------------
module e1_loopback_alarm_control
  import e1_loop_pkg::*;
#(
  parameter int unsigned UPD_SLOW_CYC   = `UPD_SLOW_US * 1000 / `REF_CLK_NS,
  parameter int unsigned UPD_FAST_CYC   = `UPD_FAST_US * 1000 / `REF_CLK_NS,
  parameter int unsigned CRC_LATE_CYC   = `CRC_LATE_US * 1000 / `REF_CLK_NS,
  parameter int unsigned CRC_FAIL_CYC   = `CRC_FAIL_US * 1000 / `REF_CLK_NS,
  parameter int unsigned TXCLK_DEAD_CYC = `TXCLK_DEAD_CYC,
  parameter int          FIFO_DEPTH     = 32,
  parameter int          VIOL_W         = 16
) (
  // clocks and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              rx_line_clk_i,
  input  wire logic              tx_clock_in_i,
  // host register port
  input  wire logic              host_cs_i,
  input  wire logic              host_wr_i,
  input  wire logic              host_rd_i,
  input  wire logic [7:0]        host_addr_i,
  input  wire logic [7:0]        host_wdata_i,
  output logic [7:0]             host_rdata_o,
  // transmit formatter stream
  input  wire logic              tx_valid_i,
  input  wire logic              tx_pos_i,
  input  wire logic              tx_neg_i,
  output logic                   tx_ready_o,
  // transmit slot tap
  input  wire logic              tx_slot_stb_i,
  input  wire logic [4:0]        tx_slot_num_i,
  input  wire logic [7:0]        tx_slot_data_i,
  // line pins, link domain
  input  wire logic              line_rx_pos_in_i,
  input  wire logic              line_rx_neg_in_i,
  output logic                   line_tx_pos_out_o,
  output logic                   line_tx_neg_out_o,
  // receive framer feed, link domain
  output logic                   framer_rx_pos_o,
  output logic                   framer_rx_neg_o,
  // receive framer status
  input  wire logic              frame_sync_loss_i,
  input  wire logic              ais_detect_i,
  input  wire logic              crc4_enable_i,
  input  wire logic              crc4_mf_sync_i,
  input  wire logic              bpv_event_i,
  input  wire logic              cv_event_i,
  input  wire logic              rx_data_i,
  // framer loop control, ref domain
  input  wire logic              framer_loop_enable_i,
  // results
  output logic                   rx_serial_out_o,
  output logic                   tx_ais_o,
  output logic                   tx_remote_alarm_o,
  output logic                   rx_carrier_loss_o,
  output logic                   err_latch_o,
  output logic [VIOL_W-1:0]      viol_count_o,
  output logic                   tx_clk_from_rx_o,
  output logic                   tx_clock_out_o,
  output logic                   rx_clock_out_o
);
  if (VIOL_W < 1 || UPD_FAST_CYC < 2 || CRC_LATE_CYC >= CRC_FAIL_CYC
      || TXCLK_DEAD_CYC < 4 || TXCLK_DEAD_CYC > 65536) begin : g_bad_params
    $error("unsupported parameter values");
  end

  //----------------------------------------------------------------------------
  // host registers
  //----------------------------------------------------------------------------
  reg_byte_t   cc2_q, cc3_q, tx_mon_q;
  logic        host_wr, host_rd;
  logic        carrier_loss_ref, tx_clk_dead_q, crc_late, crc_fail;
  logic [7:0]  stat;

  assign host_wr = host_cs_i && host_wr_i;
  assign host_rd = host_cs_i && host_rd_i;
  assign stat    = {2'h0, crc_fail, crc_late, tx_clk_dead_q, tx_clk_from_rx_o,
                    tx_remote_alarm_o, carrier_loss_ref};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cc2_q <= `CC2_RESET;
      cc3_q <= `CC3_RESET;
    end else if (host_wr) begin
      if (host_addr_i == `CC2_ADDR) begin
        cc2_q <= host_wdata_i;
      end
      if (host_addr_i == `CC3_ADDR) begin
        cc3_q <= host_wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      host_rdata_o <= 8'h00;
    end else if (host_rd) begin
      case (host_addr_i)
        `CC2_ADDR:       host_rdata_o <= cc2_q;
        `CC3_ADDR:       host_rdata_o <= cc3_q;
        `TX_MON_ADDR:    host_rdata_o <= tx_mon_q;
        `LOOP_STAT_ADDR: host_rdata_o <= stat;
        default:         host_rdata_o <= 8'h00;
      endcase
    end
  end

  // slot monitor copies the selected slot each frame
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_mon_q <= 8'h00;
    end else if (tx_slot_stb_i
                 && tx_slot_num_i == cc3_q[`CC3_MON_SEL_MSB:`CC3_MON_SEL_LSB]) begin
      tx_mon_q <= tx_slot_data_i;
    end
  end

  //----------------------------------------------------------------------------
  // error counter update and violation counter
  //----------------------------------------------------------------------------
  logic [31:0]       upd_cnt_q;
  logic [31:0]       upd_limit;
  logic [VIOL_W-1:0] viol_q;
  logic              viol_hit;

  assign upd_limit = cc2_q[`CC2_UPD_SEL] ? 32'(UPD_FAST_CYC - 1)
                                         : 32'(UPD_SLOW_CYC - 1);
  assign viol_hit  = cc2_q[`CC2_VIOL_SEL] ? cv_event_i : bpv_event_i;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      upd_cnt_q   <= '0;
      err_latch_o <= 1'b0;
    end else if (upd_cnt_q >= upd_limit) begin
      upd_cnt_q   <= '0;
      err_latch_o <= 1'b1;
    end else begin
      upd_cnt_q   <= upd_cnt_q + 32'h1;
      err_latch_o <= 1'b0;
    end
  end

  // an event in the latch cycle is carried into the next period, never lost
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      viol_q       <= '0;
      viol_count_o <= '0;
    end else if (err_latch_o) begin
      viol_count_o <= viol_q;
      viol_q       <= {{(VIOL_W-1){1'b0}}, viol_hit};
    end else if (viol_hit && viol_q != '1) begin
      viol_q <= viol_q + 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // receive serial output
  //----------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_serial_out_o <= 1'b1;
    end else begin
      rx_serial_out_o <= (cc2_q[`CC2_RX_SER_FORCE] && frame_sync_loss_i)
                         ? 1'b1 : rx_data_i;
    end
  end

  //----------------------------------------------------------------------------
  // transmit clock watchdog and clock selection
  //----------------------------------------------------------------------------
  logic [2:0]  tx_clock_in_sync_q;
  logic [15:0] tx_clock_in_idle_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_clock_in_sync_q <= 3'h0;
    end else begin
      tx_clock_in_sync_q <= {tx_clock_in_sync_q[1:0], tx_clock_in_i};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_clock_in_idle_q   <= '0;
      tx_clk_dead_q <= 1'b0;
    end else if (tx_clock_in_sync_q[2] != tx_clock_in_sync_q[1]) begin
      tx_clock_in_idle_q   <= '0;
      tx_clk_dead_q <= 1'b0;
    end else if (tx_clock_in_idle_q >= 16'(TXCLK_DEAD_CYC - 1)) begin
      tx_clk_dead_q <= 1'b1;
    end else begin
      tx_clock_in_idle_q <= tx_clock_in_idle_q + 16'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_clk_from_rx_o <= 1'b0;
    end else begin
      tx_clk_from_rx_o <= cc2_q[`CC2_CLK_SRC_SEL]
                          || (cc2_q[`CC2_CLK_LOSS_MUX] && tx_clk_dead_q);
    end
  end

  // plain clock muxes: a select change may clip one clock period, fine for a fallback path
  assign tx_clock_out_o = tx_clk_from_rx_o ? rx_line_clk_i : tx_clock_in_i;
  assign rx_clock_out_o = framer_loop_enable_i ? tx_clock_in_i : rx_line_clk_i;

  //----------------------------------------------------------------------------
  // crc4 multiframe search timer
  //----------------------------------------------------------------------------
  crc_state_e  crc_state_q;
  logic [31:0] crc_cnt_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      crc_state_q <= CRC_IDLE;
      crc_cnt_q   <= '0;
    end else begin
      case (crc_state_q)
        CRC_IDLE: begin
          crc_cnt_q <= '0;
          if (!frame_sync_loss_i && crc4_enable_i) begin
            crc_state_q <= CRC_SEARCH;
          end
        end
        CRC_SEARCH: begin
          if (frame_sync_loss_i || !crc4_enable_i) begin
            crc_state_q <= CRC_IDLE;
          end else if (crc4_mf_sync_i) begin
            crc_state_q <= CRC_FOUND;
          end else if (crc_cnt_q < 32'(CRC_FAIL_CYC)) begin
            crc_cnt_q <= crc_cnt_q + 32'h1;
          end
        end
        CRC_FOUND: begin
          if (frame_sync_loss_i || !crc4_enable_i || !crc4_mf_sync_i) begin
            crc_state_q <= CRC_IDLE;
          end
        end
        default: crc_state_q <= CRC_IDLE;
      endcase
    end
  end

  assign crc_late = crc_state_q == CRC_SEARCH && crc_cnt_q >= 32'(CRC_LATE_CYC);
  assign crc_fail = crc_state_q == CRC_SEARCH && crc_cnt_q >= 32'(CRC_FAIL_CYC);

  //----------------------------------------------------------------------------
  // automatic alarms
  //----------------------------------------------------------------------------
  logic rx_trouble;

  assign rx_trouble = frame_sync_loss_i || ais_detect_i || carrier_loss_ref;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_ais_o          <= 1'b0;
      tx_remote_alarm_o <= 1'b0;
    end else begin
      tx_ais_o          <= cc2_q[`CC2_AUTO_AIS] && rx_trouble;
      tx_remote_alarm_o <= (cc2_q[`CC2_AUTO_RA] && (rx_trouble || crc_late))
                           || crc_fail;
    end
  end

  //----------------------------------------------------------------------------
  // crossings into and out of the link domain
  //----------------------------------------------------------------------------
  localparam int NCTL = 6;
  logic            flb_ref;
  logic [NCTL-1:0] ctl_ref, ctl_s1_q, ctl_s2_q;
  logic [1:0]      lrst_q;
  logic            link_rst;
  logic [1:0]      rcl_sync_q;

  // framer loop bit sits in a control register outside this block, so it comes in as a port
  assign flb_ref = framer_loop_enable_i;
  assign ctl_ref = {flb_ref, cc3_q[`CC3_LOCAL_LOOP], cc3_q[`CC3_REMOTE_LOOP],
                    cc3_q[`CC3_LINE_AIS], cc2_q[`CC2_RCL_ALT], tx_ais_o};

  // link logic resets only while its clock runs
  always_ff @(posedge rx_line_clk_i) begin
    lrst_q <= {lrst_q[0], rst_i};
  end
  assign link_rst = lrst_q[1];

  for (genvar i = 0; i < NCTL; i++) begin : g_ctl_sync
    always_ff @(posedge rx_line_clk_i) begin
      ctl_s1_q[i] <= ctl_ref[i];
      ctl_s2_q[i] <= ctl_s1_q[i];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rcl_sync_q <= 2'h0;
    end else begin
      rcl_sync_q <= {rcl_sync_q[0], rx_carrier_loss_o};
    end
  end
  assign carrier_loss_ref = rcl_sync_q[1];

  //----------------------------------------------------------------------------
  // transmit fifo
  //----------------------------------------------------------------------------
  logic       fifo_valid;
  logic [1:0] fifo_data;

  e1_tx_fifo #(
    .W     (2),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .wclk_i    (ref_clk_i),
    .wrst_i    (rst_i),
    .w_valid_i (tx_valid_i),
    .w_data_i  ({tx_pos_i, tx_neg_i}),
    .w_ready_o (tx_ready_o),
    .rclk_i    (rx_line_clk_i),
    .rrst_i    (link_rst),
    .r_valid_o (fifo_valid),
    .r_ready_i (1'b1),
    .r_data_o  (fifo_data)
  );

  //----------------------------------------------------------------------------
  // link domain data paths
  //----------------------------------------------------------------------------
  logic [1:0]  lrx_s1_q, lrx_s2_q, fmt_word, tx_word, ones_word, rx_word;
  logic        ami_q;
  logic [11:0] zero_run_q;
  logic        l_flb, l_llb, l_rlb, l_lais, l_carrier_loss_alt_criteria, l_auto_alarm_all_ones_en;

  assign {l_flb, l_llb, l_rlb, l_lais, l_carrier_loss_alt_criteria, l_auto_alarm_all_ones_en} = ctl_s2_q;
  assign ones_word = ami_q ? 2'h2 : 2'h1;
  // formatter word, an empty fifo sends a space; auto AIS replaces it by all ones
  assign fmt_word  = l_auto_alarm_all_ones_en ? ones_word : (fifo_valid ? fifo_data : 2'h0);
  assign tx_word   = l_lais ? ones_word
                   : (l_rlb ? lrx_s2_q : fmt_word);
  assign rx_word   = (l_flb || l_llb) ? fmt_word : lrx_s2_q;

  always_ff @(posedge rx_line_clk_i) begin
    if (link_rst) begin
      lrx_s1_q <= 2'h0;
      lrx_s2_q <= 2'h0;
    end else begin
      lrx_s1_q <= {line_rx_pos_in_i, line_rx_neg_in_i};
      lrx_s2_q <= lrx_s1_q;
    end
  end

  always_ff @(posedge rx_line_clk_i) begin
    if (link_rst) begin
      ami_q             <= 1'b0;
      line_tx_pos_out_o <= 1'b0;
      line_tx_neg_out_o <= 1'b0;
      framer_rx_pos_o   <= 1'b0;
      framer_rx_neg_o   <= 1'b0;
    end else begin
      ami_q             <= ~ami_q;
      {line_tx_pos_out_o, line_tx_neg_out_o} <= tx_word;
      {framer_rx_pos_o, framer_rx_neg_o}     <= rx_word;
    end
  end

  // carrier loss watches what the framer is fed, so while a framer or local loop is on looped data counts, line data does not
  always_ff @(posedge rx_line_clk_i) begin
    if (link_rst) begin
      zero_run_q        <= '0;
      rx_carrier_loss_o <= 1'b0;
    end else if (rx_word != 2'h0) begin
      zero_run_q        <= '0;
      rx_carrier_loss_o <= 1'b0;
    end else begin
      if (zero_run_q != `RCL_ZEROS_ALT) begin
        zero_run_q <= zero_run_q + 12'h1;
      end
      if (zero_run_q + 12'h1 >= (l_carrier_loss_alt_criteria ? `RCL_ZEROS_ALT : `RCL_ZEROS_STD)) begin
        rx_carrier_loss_o <= 1'b1;
      end
    end
  end
endmodule // e1_loopback_alarm_control

/* dv/e1_loop_alarm_sva.sv */
// checker for host, alarm, clock source and latch outputs
`timescale 1ns/1ps
module e1_loop_alarm_sva #(
  parameter int unsigned UPD_SLOW_CYC = 200,
  parameter int unsigned UPD_FAST_CYC = 50
) (
  // clock, reset, host port
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       host_cs_i,
  input wire logic       host_wr_i,
  input wire logic       host_rd_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [7:0] host_rdata_o,
  // status in, results out
  input wire logic       frame_sync_loss_i,
  input wire logic       ais_detect_i,
  input wire logic       rx_data_i,
  input wire logic       rx_serial_out_o,
  input wire logic       tx_ais_o,
  input wire logic       tx_remote_alarm_o,
  input wire logic       err_latch_o,
  input wire logic       tx_clk_from_rx_o
);
  logic [7:0]  cc2_q;
  logic [31:0] gap_q;
  logic        same_q;
  logic        wr_cc2;
  assign wr_cc2 = host_cs_i && host_wr_i && host_addr_i == 8'h13;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) cc2_q <= 8'h00;
    else if (wr_cc2) cc2_q <= host_wdata_i;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || err_latch_o) gap_q <= 32'h1;
    else gap_q <= gap_q + 32'h1;
  end
  // a rate change voids the next period comparison
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || (wr_cc2 && host_wdata_i[7] != cc2_q[7])) same_q <= 1'b0;
    else if (err_latch_o) same_q <= 1'b1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd_unmapped;
    host_cs_i && host_rd_i && !(host_addr_i inside {8'h13, 8'h14, 8'h1e, 8'h1f});
  endsequence
  sequence s_ais_cause;
    (cc2_q[5] && (frame_sync_loss_i || ais_detect_i))[*4];
  endsequence
  sequence s_ra_cause;
    (cc2_q[4] && (frame_sync_loss_i || ais_detect_i))[*4];
  endsequence
  chk_unmapped_zero: assert property (s_rd_unmapped |=> host_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!(host_cs_i && host_rd_i) |=> $stable(host_rdata_o))
    else $error("read data moved");
  chk_auto_ais: assert property (s_ais_cause |-> tx_ais_o)
    else $error("auto ais missing");
  chk_auto_ra: assert property (s_ra_cause |-> tx_remote_alarm_o)
    else $error("auto remote alarm missing");
  chk_rx_serial_out_force: assert property ((cc2_q[3] && frame_sync_loss_i)[*3] |-> rx_serial_out_o)
    else $error("serial out not forced");
  chk_rx_serial_out_pass: assert property ((!cc2_q[3] && $stable(rx_data_i))[*3]
    |-> rx_serial_out_o == rx_data_i) else $error("serial out not passed");
  chk_src_rx: assert property (cc2_q[0][*3] |-> tx_clk_from_rx_o)
    else $error("clock source not receive");
  chk_src_pin: assert property ((!cc2_q[0] && !cc2_q[2])[*3] |-> !tx_clk_from_rx_o)
    else $error("clock source moved");
  chk_latch_pulse: assert property (err_latch_o |=> !err_latch_o)
    else $error("latch pulse too long");
  chk_latch_period: assert property (err_latch_o && same_q
    |-> gap_q == (cc2_q[7] ? UPD_FAST_CYC : UPD_SLOW_CYC)) else $error("latch period wrong");
endmodule // e1_loop_alarm_sva

bind e1_loopback_alarm_control e1_loop_alarm_sva #(
  .UPD_SLOW_CYC(UPD_SLOW_CYC), .UPD_FAST_CYC(UPD_FAST_CYC)) e1_loop_alarm_sva_inst (.*);

/* dv/e1_line_far_end.sv */
// far end of the line: drives the receive pins on the recovered clock
`timescale 1ns/1ps
module e1_line_far_end (
  // link clock and control
  input  wire logic rx_line_clk_i,
  input  wire logic marks_i,
  // line pins
  output logic      line_rx_pos_in_o,
  output logic      line_rx_neg_in_o
);
  logic ph_q = 1'b0;
  // polarity alternates every clock, so marks an odd number of clocks apart form legal bipolar pulses
  always @(posedge rx_line_clk_i) begin
    ph_q <= ~ph_q;
    line_rx_pos_in_o <= marks_i & ph_q;
    line_rx_neg_in_o <= marks_i & ~ph_q;
  end
endmodule // e1_line_far_end

/* dv/e1_loopback_alarm_control_tb.sv */
// self-checking bench for the loop/alarm block
`timescale 1ns/1ps
module e1_loopback_alarm_control_tb;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, rx_line_clk_i = 1'b0, tx_clock_in_i = 1'b0;
  logic host_cs_i = 1'b0, host_wr_i = 1'b0, host_rd_i = 1'b0;
  logic [7:0] host_addr_i = 8'h00, host_wdata_i = 8'h00, host_rdata_o, tx_slot_data_i = 8'h00;
  logic tx_valid_i = 1'b0, tx_pos_i = 1'b1, tx_neg_i = 1'b0, tx_ready_o, tx_slot_stb_i = 1'b0;
  logic [4:0] tx_slot_num_i = 5'h00;
  logic line_rx_pos_in_i, line_rx_neg_in_i, line_tx_pos_out_o, line_tx_neg_out_o;
  logic framer_rx_pos_o, framer_rx_neg_o, rx_data_i = 1'b0, crc4_enable_i = 1'b0;
  logic frame_sync_loss_i = 1'b0, ais_detect_i = 1'b0, crc4_mf_sync_i = 1'b0;
  logic bpv_event_i = 1'b0, cv_event_i = 1'b0, rx_serial_out_o, tx_ais_o, tx_remote_alarm_o;
  logic rx_carrier_loss_o, err_latch_o, tx_clk_from_rx_o, tx_clock_out_o, rx_clock_out_o;
  logic [15:0] viol_count_o;
  logic marks = 1'b1, txc_run = 1'b1, framer_loop_enable_i = 1'b0;
  int err_total = 0, checks_done = 0, n_line = 0, n_frm = 0, n = 0, k = 0;

  e1_loopback_alarm_control #(.UPD_SLOW_CYC(200), .UPD_FAST_CYC(50), .CRC_LATE_CYC(100),
    .CRC_FAIL_CYC(300), .TXCLK_DEAD_CYC(64)) e1_loopback_alarm_control_inst (.*);
  e1_line_far_end e1_line_far_end_inst (.rx_line_clk_i(rx_line_clk_i), .marks_i(marks),
    .line_rx_pos_in_o(line_rx_pos_in_i), .line_rx_neg_in_o(line_rx_neg_in_i));

  always #2.5 ref_clk_i = ~ref_clk_i;
  always #32 rx_line_clk_i = ~rx_line_clk_i;
  always @(posedge ref_clk_i) if (txc_run) tx_clock_in_i <= ~tx_clock_in_i;
  // link outputs move on the rising edge, so count marks on the falling one
  always @(negedge rx_line_clk_i) begin
    n_line += int'(line_tx_pos_out_o ^ line_tx_neg_out_o);
    n_frm += int'(framer_rx_pos_o ^ framer_rx_neg_o);
  end

  //----------------------------------------------------------------------------
  // tasks
  //----------------------------------------------------------------------------
  task automatic finish_test();
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    #1;
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask
  task automatic lnk(input int c);
    repeat (c) @(posedge rx_line_clk_i);
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge ref_clk_i);
    host_addr_i <= a;
    host_wdata_i <= d;
    host_cs_i <= 1'b1;
    host_wr_i <= w;
    host_rd_i <= !w;
    @(posedge ref_clk_i);
    host_cs_i <= 1'b0;
    host_wr_i <= 1'b0;
    host_rd_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 1'b1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    acc(a, 8'h00, 1'b0);
    @(posedge ref_clk_i);
    chk(host_rdata_o, e);
  endtask
  task automatic wait_latch();
    k = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end while (err_latch_o !== 1'b1 && k < 1000);
  endtask
  task automatic viol_chk(input logic [7:0] cfg, input int gap, input logic [15:0] e);
    wr(8'h13, cfg);
    wait_latch();
    wait_latch();
    chk(16'(k), 16'(gap));
    @(posedge ref_clk_i);
    for (int i = 0; i < 5; i++) begin
      bpv_event_i <= (i < 3);
      cv_event_i <= 1'b1;
      @(posedge ref_clk_i);
      bpv_event_i <= 1'b0;
      cv_event_i <= 1'b0;
      @(posedge ref_clk_i);
    end
    wait_latch();
    cyc(2);
    chk(viol_count_o, e);
  endtask
  task automatic marks_chk(input logic [7:0] cfg, input int el, input int ef);
    wr(8'h14, cfg);
    lnk(6);
    n_line = 0;
    n_frm = 0;
    lnk(8);
    chk(16'(n_line), 16'(el));
    chk(16'(n_frm), 16'(ef));
  endtask

  //----------------------------------------------------------------------------
  // tests
  //----------------------------------------------------------------------------
  initial begin
    cyc(12);
    rst_i <= 1'b0;
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h14, 8'h00);
    rd_chk(8'h20, 8'h00);
    wr(8'h13, 8'ha5);
    rd_chk(8'h13, 8'ha5);
    frame_sync_loss_i <= 1'b1;
    wr(8'h13, 8'h08);
    cyc(4);
    chk({tx_ais_o, tx_remote_alarm_o, rx_serial_out_o}, 3'b001);
    for (int i = 0; i < 2; i++) begin
      frame_sync_loss_i <= (i == 0);
      ais_detect_i <= (i == 1);
      wr(8'h13, 8'h30);
      cyc(4);
      chk({tx_ais_o, tx_remote_alarm_o, rx_serial_out_o}, 3'b110);
    end
    ais_detect_i <= 1'b0;
    cyc(4);
    chk({tx_ais_o, tx_remote_alarm_o}, 2'b00);
    wr(8'h13, 8'h01);
    cyc(4);
    chk(tx_clk_from_rx_o, 1'b1);
    chk(tx_clock_out_o, rx_line_clk_i);
    wr(8'h13, 8'h04);
    txc_run <= 1'b0;
    cyc(100);
    chk(tx_clk_from_rx_o, 1'b1);
    wr(8'h13, 8'h00);
    cyc(4);
    chk(tx_clk_from_rx_o, 1'b0);
    txc_run <= 1'b1;
    viol_chk(8'h80, 50, 16'd3);
    viol_chk(8'h40, 200, 16'd5);
    wr(8'h13, 8'h30);
    marks <= 1'b0;
    lnk(200);
    marks <= 1'b1;
    lnk(1);
    marks <= 1'b0;
    lnk(200);
    chk(rx_carrier_loss_o, 1'b0);
    lnk(100);
    chk({rx_carrier_loss_o, tx_ais_o, tx_remote_alarm_o}, 3'b111);
    rd_chk(8'h1f, 8'h03);
    marks <= 1'b1;
    wr(8'h13, 8'h02);
    lnk(20);
    marks <= 1'b0;
    lnk(300);
    chk(rx_carrier_loss_o, 1'b0);
    lnk(1800);
    chk(rx_carrier_loss_o, 1'b1);
    marks <= 1'b1;
    lnk(20);
    chk(rx_carrier_loss_o, 1'b0);
    wr(8'h13, 8'h10);
    crc4_enable_i <= 1'b1;
    cyc(150);
    chk(tx_remote_alarm_o, 1'b1);
    crc4_enable_i <= 1'b0;
    wr(8'h13, 8'h00);
    crc4_enable_i <= 1'b1;
    cyc(150);
    chk(tx_remote_alarm_o, 1'b0);
    cyc(200);
    chk(tx_remote_alarm_o, 1'b1);
    crc4_enable_i <= 1'b0;
    lnk(1);
    n_line = 0;
    @(posedge ref_clk_i);
    tx_valid_i <= 1'b1;
    repeat (60) begin
      #1 k = int'(tx_ready_o);
      @(posedge ref_clk_i);
      n += k;
    end
    tx_valid_i <= 1'b0;
    chk(16'(k), 16'd0);
    lnk(60);
    chk(16'(n_line), 16'(n));
    marks_chk(8'h80, 8, 8);
    marks_chk(8'h20, 8, 8);
    marks_chk(8'h40, 0, 0);
    framer_loop_enable_i <= 1'b1;
    marks_chk(8'h00, 0, 0);
    cyc(1);
    chk(rx_clock_out_o, tx_clock_in_i);
    cyc(1);
    chk(rx_clock_out_o, tx_clock_in_i);
    framer_loop_enable_i <= 1'b0;
    wr(8'h14, 8'h05);
    tx_slot_num_i <= 5'h05;
    tx_slot_data_i <= 8'ha5;
    tx_slot_stb_i <= 1'b1;
    @(posedge ref_clk_i);
    tx_slot_num_i <= 5'h06;
    tx_slot_data_i <= 8'h3c;
    @(posedge ref_clk_i);
    tx_slot_stb_i <= 1'b0;
    wr(8'h1e, 8'hff);
    rd_chk(8'h1e, 8'ha5);
    finish_test();
  end
  initial begin
    #400000;
    err_total++;
    finish_test();
  end
endmodule // e1_loopback_alarm_control_tb
